// *** src/wetdc_pkg.sv ***
`default_nettype none
package wetdc_pkg;
    // Core clock and slow oscillator rates
    localparam int CLK_KHZ = 40000;
    localparam int SLOW_BASE_KHZ = 32;
    localparam int SLOW_DIV_BASE = CLK_KHZ / SLOW_BASE_KHZ;
    localparam int REF_SHIFT = 8;
    localparam int READY_DLY_US = 6000;
    localparam int READY_DLY_CYC = READY_DLY_US * CLK_KHZ / 1000;
    localparam int PIN_PULSE_US = 1;
    localparam int PIN_PULSE_CYC = PIN_PULSE_US * CLK_KHZ / 1000;
    // Wake source byte fields and wake event codes
    localparam int SRC_TIMEOUT = 0;
    localparam int SRC_TAG = 1;
    localparam int SRC_PIN = 3;
    localparam int SRC_SS = 4;
    localparam int SRC_RATE_LSB = 6;
    localparam logic [7:0] WAKE_TIMEOUT = 8'h01;
    localparam logic [7:0] WAKE_TAG = 8'h02;
    localparam logic [7:0] WAKE_PIN = 8'h08;
    localparam logic [7:0] WAKE_SS = 8'h10;
    localparam logic [4:0] MAX_SLEEP_TOP = 5'h1f;
    localparam int DAC_SHIFT = 2;
    // Calibration sweep
    localparam logic [7:0] CAL_HI_START = 8'hfe;
    localparam logic [7:0] CAL_GUARD = 8'h08;
    localparam logic [7:0] CAL_MAX_SLEEP = 8'h01;
    localparam logic [7:0] CAL_SRC = 8'h03;
    // Host register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_SRC = 12'h004;
    localparam logic [11:0] REG_TIMING = 12'h008;
    localparam logic [11:0] REG_THRESH = 12'h00c;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam int CTRL_GO = 0;
    localparam int CTRL_PIN = 1;
    localparam int CTRL_SS = 2;
    localparam int CTRL_CAL = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_FORCE_PIN = 8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_READY = 1;
    localparam int STAT_VALID = 2;
    localparam int STAT_ERR = 3;
    localparam int STAT_CAL_DONE = 4;
    localparam int STAT_CODE_LSB = 8;
    localparam int STAT_DAC_LSB = 16;
    localparam int STAT_REF_LSB = 24;
    localparam logic [7:0] SRC_RESET = 8'h08;
    localparam logic [31:0] TIMING_RESET = 32'h3f606020;
    localparam logic [23:0] THRESH_RESET = 24'h087464;

    typedef enum logic [1:0] {MODE_HIBERNATE, MODE_SLEEP, MODE_TAG, MODE_CAL} wetdc_mode_e;
endpackage : wetdc_pkg
`default_nettype wire

// *** src/wetdc_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface wetdc_if;
    import wetdc_pkg::*;
    // Wake pins, idle command and wake answer
    logic wake_n;
    logic ss_n;
    logic cmd_valid;
    logic cmd_ready;
    logic cmd_err;
    logic wake_valid;
    logic [7:0] cmd_src;
    logic [7:0] cmd_period;
    logic [7:0] cmd_osc;
    logic [7:0] cmd_dac;
    logic [7:0] cmd_lo;
    logic [7:0] cmd_hi;
    logic [7:0] cmd_swing;
    logic [7:0] cmd_max;
    logic [7:0] wake_code;
    logic [5:0] dac_data;
    wetdc_mode_e cmd_mode;
    modport dev (input wake_n, ss_n, cmd_valid, cmd_src, cmd_period, cmd_osc, cmd_dac, cmd_lo,
        cmd_hi, cmd_swing, cmd_max, cmd_mode, output cmd_ready, cmd_err, wake_valid, wake_code, dac_data);
    modport hst (output wake_n, ss_n, cmd_valid, cmd_src, cmd_period, cmd_osc, cmd_dac, cmd_lo,
        cmd_hi, cmd_swing, cmd_max, cmd_mode, input cmd_ready, cmd_err, wake_valid, wake_code, dac_data);
endinterface : wetdc_if
`default_nettype wire

// *** src/wetdc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module wetdc_host
    import wetdc_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    wetdc_if.hst link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} wetdc_hst_e;
    typedef struct packed {
        wetdc_hst_e st;
        logic go_req;
        logic pin_req;
        logic ss_req;
        logic cal_req;
        logic [15:0] pcnt;
        logic pulse_ss;
        wetdc_mode_e mode;
        logic force_pin;
        logic [7:0] src;
        logic [31:0] timing;
        logic [23:0] thresh;
        logic busy_err;
        logic code_valid;
        logic cal_active;
        logic cal_done;
        logic [7:0] cal_ref;
        logic [7:0] code;
        logic [5:0] dac;
        logic wake_n;
        logic ss_n;
        logic cmd_valid;
        wetdc_mode_e cmd_mode;
        logic [7:0] cmd_src;
        logic [7:0] cmd_lo;
        logic [7:0] cmd_hi;
        logic [7:0] cmd_max;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } wetdc_hstate_s;

    wetdc_hstate_s r;
    wetdc_hstate_s n;

    // Read decode of the host register map
    function automatic logic [32:0] rd_word(input logic [11:0] a, input wetdc_hstate_s s, input logic rdy);
        logic [31:0] st;
        st = '0;
        st[STAT_BUSY] = (s.st != H_IDLE);
        st[STAT_READY] = rdy;
        st[STAT_VALID] = s.code_valid;
        st[STAT_ERR] = s.busy_err;
        st[STAT_CAL_DONE] = s.cal_done;
        st[STAT_CODE_LSB +: 8] = s.code;
        st[STAT_DAC_LSB +: 6] = s.dac;
        st[STAT_REF_LSB +: 8] = s.cal_ref;
        unique case (a)
            REG_CTRL: rd_word = {1'b0, 23'h0, s.force_pin, 2'h0, s.mode, 4'h0};
            REG_SRC: rd_word = {1'b0, 24'h0, s.src};
            REG_TIMING: rd_word = {1'b0, s.timing};
            REG_THRESH: rd_word = {1'b0, 8'h0, s.thresh};
            REG_STATUS: rd_word = {1'b0, st};
            default: rd_word = {1'b1, 32'h0};
        endcase
    endfunction : rd_word

    // Max sleep must lie strictly between zero and the top code
    function automatic logic max_bad(input logic [7:0] m);
        max_bad = (m[4:0] == 5'h00) || (m[4:0] == MAX_SLEEP_TOP);
    endfunction : max_bad

    // Next state: pulse generator, command sequencer, calibration sweep, bus slave
    always_comb begin
        logic [32:0] rd;
        logic [7:0] src_out;
        rd = rd_word(paddr, r, link.cmd_ready);
        src_out = r.src | (r.force_pin ? WAKE_PIN : 8'h00);
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        if (r.pcnt != '0) begin
            n.pcnt = r.pcnt - 16'd1;
        end else if (r.pin_req || r.ss_req) begin
            n.pcnt = 16'(PIN_PULSE_CYC);
            n.pulse_ss = r.ss_req && !r.pin_req;
            n.pin_req = 1'b0;
            n.ss_req = r.pin_req ? r.ss_req : 1'b0;
        end
        n.wake_n = !(n.pcnt != '0 && !n.pulse_ss);
        n.ss_n = !(n.pcnt != '0 && n.pulse_ss);
        unique case (r.st)
            H_IDLE: begin
                if (r.cal_req) begin
                    n.cal_req = 1'b0;
                    n.cal_active = 1'b1;
                    n.cal_done = 1'b0;
                    n.cmd_mode = MODE_CAL;
                    n.cmd_src = CAL_SRC | (src_out & 8'hc8);
                    n.cmd_lo = 8'h00;
                    n.cmd_hi = CAL_HI_START;
                    n.cmd_max = CAL_MAX_SLEEP;
                    n.busy_err = 1'b0;
                    n.st = H_SEND;
                end else if (r.go_req) begin
                    n.go_req = 1'b0;
                    n.cmd_mode = r.mode;
                    n.cmd_src = src_out;
                    n.cmd_lo = r.thresh[7:0];
                    n.cmd_hi = r.thresh[15:8];
                    n.cmd_max = r.thresh[23:16];
                    n.busy_err = (r.mode != MODE_HIBERNATE) && max_bad(r.thresh[23:16]);
                    n.code_valid = 1'b0;
                    n.st = n.busy_err ? H_IDLE : H_SEND;
                end
            end
            H_SEND: begin
                n.cmd_valid = 1'b1;
                if (r.cmd_valid && link.cmd_ready) begin
                    n.cmd_valid = 1'b0;
                    n.st = H_WAIT;
                end
            end
            H_WAIT: begin
                if (link.cmd_err) begin
                    n.busy_err = 1'b1;
                    n.cal_active = 1'b0;
                    n.st = H_IDLE;
                end else if (link.wake_valid) begin
                    n.code = link.wake_code;
                    n.dac = link.dac_data;
                    n.code_valid = (r.cmd_mode != MODE_HIBERNATE);
                    n.st = H_IDLE;
                    if (r.cal_active && link.wake_code == WAKE_TIMEOUT && r.cmd_hi != 8'h00) begin
                        n.cmd_hi = r.cmd_hi - 8'd1;
                        n.st = H_SEND;
                    end else if (r.cal_active) begin
                        n.cal_active = 1'b0;
                        n.cal_done = 1'b1;
                        n.cal_ref = r.cmd_hi;
                        n.thresh[7:0] = (r.cmd_hi > CAL_GUARD) ? r.cmd_hi - CAL_GUARD : 8'h00;
                        n.thresh[15:8] = (r.cmd_hi < 8'hff - CAL_GUARD) ? r.cmd_hi + CAL_GUARD : 8'hff;
                    end
                end
            end
            default: n.st = H_IDLE;
        endcase
        if (psel && !penable && !r.pready) begin
            n.pready = 1'b1;
            n.prdata = rd[31:0];
            n.pslverr = rd[32];
        end
        if (psel && penable && r.pready && pwrite) begin
            unique case (paddr)
                REG_CTRL: begin
                    n.go_req = n.go_req | pwdata[CTRL_GO];
                    n.pin_req = n.pin_req | pwdata[CTRL_PIN];
                    n.ss_req = n.ss_req | pwdata[CTRL_SS];
                    n.cal_req = n.cal_req | pwdata[CTRL_CAL];
                    n.mode = wetdc_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
                    n.force_pin = pwdata[CTRL_FORCE_PIN];
                end
                REG_SRC: n.src = pwdata[7:0];
                REG_TIMING: n.timing = pwdata;
                REG_THRESH: n.thresh = pwdata[23:0];
                default: n.src = r.src;
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.st <= H_IDLE;
            r.mode <= MODE_SLEEP;
            r.cmd_mode <= MODE_SLEEP;
            r.force_pin <= 1'b1;
            r.src <= SRC_RESET;
            r.timing <= TIMING_RESET;
            r.thresh <= THRESH_RESET;
            r.wake_n <= 1'b1;
            r.ss_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign link.wake_n = r.wake_n;
    assign link.ss_n = r.ss_n;
    assign link.cmd_valid = r.cmd_valid;
    assign link.cmd_mode = r.cmd_mode;
    assign link.cmd_src = r.cmd_src;
    assign link.cmd_lo = r.cmd_lo;
    assign link.cmd_hi = r.cmd_hi;
    assign link.cmd_max = r.cmd_max;
    assign link.cmd_period = r.timing[7:0];
    assign link.cmd_osc = r.timing[15:8];
    assign link.cmd_dac = r.timing[23:16];
    assign link.cmd_swing = r.timing[31:24];
endmodule : wetdc_host
`default_nettype wire

// *** src/wetdc_dev.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - gap and hibernate stop fast oscillator, slow ticks
// - reference is 256 slow periods, rate bits
// - several wake sources may be enabled
// - host enables the pin source while force_pin is set
// - power-up waits pin pulse, ready 6 ms later
// - hibernate wakes only on the pin
// - host ignores wake flag after hibernate
// - sleep wakes on pin or select pulse
// - timeout is reference times gap times trials
// - burst limit five bits, strictly inside range
// - timer and pin sources with rate accepted
// - bursts only with tag source enabled
// - timeout bit limits bursts, else endless
// - gap lasts coefficient plus two references
// - oscillator and converter settle before burst
// - burst lasts swing count carrier swings
// - burst measures drive current, 6 bits
// - outside thresholds means tag detected
// - calibration sweeps high threshold downward
// - guard band of 0x08 around reference
// - calibration uses the same timing parameters
// - command bytes give source, thresholds, limit
module wetdc_dev
    import wetdc_pkg::*;
#(
    parameter int READY_DLY = READY_DLY_CYC,
    parameter int SLOW_DIV = SLOW_DIV_BASE
) (
    input wire logic core_clk,
    input wire logic nrst,
    wetdc_if.dev link,
    input wire logic [5:0] drive_current,
    output logic fast_osc_en,
    output logic rf_on,
    output logic wait_active
);
    typedef enum logic [2:0] {D_PWRUP, D_BOOT, D_READY, D_HIB, D_GAP, D_OSC, D_DAC, D_BURST} wetdc_dst_e;
    typedef struct packed {
        wetdc_dst_e st;
        logic [17:0] cnt;
        logic [13:0] div;
        logic [4:0] trials;
        logic wake_n_q;
        logic ss_n_q;
        logic [7:0] src;
        logic [7:0] period;
        logic [7:0] osc;
        logic [7:0] dac;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] swing;
        logic [4:0] maxs;
        logic cmd_ready;
        logic cmd_err;
        logic wake_valid;
        logic [7:0] wake_code;
        logic [5:0] dac_data;
        logic fast_osc_en;
        logic rf_on;
        logic wait_active;
    } wetdc_dstate_s;

    wetdc_dstate_s r;
    wetdc_dstate_s n;

    // Slow period in core cycles, minus one, set by the rate field
    function automatic logic [13:0] div_load(input logic [7:0] src);
        div_load = 14'((SLOW_DIV << src[SRC_RATE_LSB +: 2]) - 1);
    endfunction : div_load

    // Inactive gap in slow ticks, minus one
    function automatic logic [17:0] gap_len(input logic [7:0] period);
        gap_len = 18'(((18'(period) + 18'd2) << REF_SHIFT) - 18'd1);
    endfunction : gap_len

    // Falling edges on the wake pins and the slow tick
    logic pin_fall;
    logic ss_fall;
    logic tick;
    logic [7:0] meas;
    assign pin_fall = r.wake_n_q && !link.wake_n;
    assign ss_fall = r.ss_n_q && !link.ss_n;
    assign tick = (r.div == 14'h0000);
    assign meas = {drive_current, 2'b00};

    // Next state of the wait-for-event sequencer
    always_comb begin
        logic trial_end;
        logic wake_now;
        logic [7:0] code_now;
        trial_end = 1'b0;
        wake_now = 1'b0;
        code_now = 8'h00;
        n = r;
        n.cmd_err = 1'b0;
        n.wake_valid = 1'b0;
        n.wake_n_q = link.wake_n;
        n.ss_n_q = link.ss_n;
        n.div = tick ? div_load(r.src) : r.div - 14'd1;
        unique case (r.st)
            D_PWRUP: begin
                if (pin_fall) begin
                    n.st = D_BOOT;
                    n.cnt = 18'(READY_DLY - 1);
                end
            end
            D_BOOT: begin
                n.cnt = r.cnt - 18'd1;
                if (r.cnt == '0) begin
                    n.st = D_READY;
                end
            end
            D_READY: begin
                if (link.cmd_valid) begin
                    if (link.cmd_mode != MODE_HIBERNATE &&
                        (link.cmd_max[4:0] == 5'h00 || link.cmd_max[4:0] == MAX_SLEEP_TOP)) begin
                        n.cmd_err = 1'b1;
                    end else begin
                        n.src = link.cmd_src;
                        n.period = link.cmd_period;
                        n.osc = link.cmd_osc;
                        n.dac = link.cmd_dac;
                        n.lo = link.cmd_lo;
                        n.hi = link.cmd_hi;
                        n.swing = link.cmd_swing;
                        n.maxs = link.cmd_max[4:0];
                        n.trials = '0;
                        n.div = div_load(link.cmd_src);
                        n.cnt = gap_len(link.cmd_period);
                        n.st = (link.cmd_mode == MODE_HIBERNATE) ? D_HIB : D_GAP;
                    end
                end
            end
            D_HIB: begin
                if (pin_fall) begin
                    wake_now = 1'b1;
                    code_now = WAKE_PIN;
                end
            end
            D_GAP: begin
                if (tick) begin
                    n.cnt = r.cnt - 18'd1;
                    if (r.cnt == '0) begin
                        if (r.src[SRC_TAG]) begin
                            n.st = D_OSC;
                            n.cnt = 18'(r.osc);
                        end else begin
                            trial_end = 1'b1;
                        end
                    end
                end
            end
            D_OSC: begin
                if (tick) begin
                    n.cnt = r.cnt - 18'd1;
                    if (r.cnt == '0) begin
                        n.st = D_DAC;
                        n.cnt = 18'(r.dac);
                    end
                end
            end
            D_DAC: begin
                if (tick) begin
                    n.cnt = r.cnt - 18'd1;
                    if (r.cnt == '0) begin
                        n.st = D_BURST;
                        n.cnt = 18'(r.swing);
                    end
                end
            end
            D_BURST: begin
                n.cnt = r.cnt - 18'd1;
                if (r.cnt <= 18'd1) begin
                    n.dac_data = drive_current;
                    if (meas > r.hi || meas < r.lo) begin
                        wake_now = 1'b1;
                        code_now = WAKE_TAG;
                    end else begin
                        trial_end = 1'b1;
                    end
                end
            end
            default: n.st = D_PWRUP;
        endcase
        // Close one gap or burst; the timeout bit bounds the trials
        if (trial_end) begin
            if (r.src[SRC_TIMEOUT] && r.trials == r.maxs) begin
                wake_now = 1'b1;
                code_now = WAKE_TIMEOUT;
            end else begin
                n.trials = r.trials + 5'd1;
                n.st = D_GAP;
                n.cnt = gap_len(r.period);
            end
        end
        // External pulses override every other event in wait
        if (r.st inside {D_GAP, D_OSC, D_DAC, D_BURST}) begin
            if (pin_fall && r.src[SRC_PIN]) begin
                wake_now = 1'b1;
                code_now = WAKE_PIN;
            end else if (ss_fall && r.src[SRC_SS]) begin
                wake_now = 1'b1;
                code_now = WAKE_SS;
            end
        end
        if (wake_now) begin
            n.st = D_READY;
            n.wake_valid = 1'b1;
            n.wake_code = code_now;
        end
        n.cmd_ready = (n.st == D_READY);
        n.fast_osc_en = !(n.st inside {D_PWRUP, D_HIB, D_GAP});
        n.rf_on = (n.st == D_BURST);
        n.wait_active = n.st inside {D_HIB, D_GAP, D_OSC, D_DAC, D_BURST};
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.st <= D_PWRUP;
            r.wake_n_q <= 1'b1;
            r.ss_n_q <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign link.cmd_ready = r.cmd_ready;
    assign link.cmd_err = r.cmd_err;
    assign link.wake_valid = r.wake_valid;
    assign link.wake_code = r.wake_code;
    assign link.dac_data = r.dac_data;
    assign fast_osc_en = r.fast_osc_en;
    assign rf_on = r.rf_on;
    assign wait_active = r.wait_active;
endmodule : wetdc_dev
`default_nettype wire

// *** verif/wetdc_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module wetdc_assertions
    import wetdc_pkg::*;
#(
    parameter int READY_DLY = 20,
    parameter int SLOW_DIV = 4
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wake_n,
    input wire logic ss_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic cmd_err,
    input wire logic wake_valid,
    input wire logic [7:0] cmd_src,
    input wire logic [7:0] cmd_period,
    input wire logic [7:0] cmd_lo,
    input wire logic [7:0] cmd_hi,
    input wire logic [7:0] cmd_max,
    input wire logic [7:0] wake_code,
    input wire logic [5:0] dac_data,
    input var wetdc_mode_e cmd_mode
);
    logic [7:0] src_r, lo_r, hi_r;
    logic hib_r, wait_r, first_r;
    int cnt_r, lim_r, pu_r;
    wire take = cmd_valid && cmd_ready;
    wire bad = cmd_mode != MODE_HIBERNATE && (cmd_max[4:0] == 5'h00 || cmd_max[4:0] == 5'h1f);
    wire [7:0] dac8 = {dac_data, 2'b00};
    // Latch the taken command and count cycles of the wait and of power-up
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            {src_r, lo_r, hi_r, hib_r, wait_r, first_r} <= 27'h1;
            {cnt_r, lim_r, pu_r} <= '0;
        end else begin
            cnt_r <= take ? 0 : cnt_r + 1;
            if (take) begin
                {src_r, lo_r, hi_r, hib_r} <= {cmd_src, cmd_lo, cmd_hi, cmd_mode == MODE_HIBERNATE};
                lim_r <= (cmd_period + 2) * 256 * (SLOW_DIV << cmd_src[7:6]) * (cmd_max[4:0] + 1);
            end
            wait_r <= (take && !bad) || (wait_r && !wake_valid);
            first_r <= first_r && !cmd_ready;
            pu_r <= (first_r && (pu_r != 0 || !wake_n)) ? pu_r + 1 : pu_r;
        end
    end
    AST_REFUSE: assert property (@(posedge core_clk) disable iff (!nrst)
        take && bad |=> cmd_err && cmd_ready) else $error("bad burst limit not refused");
    AST_ACCEPT: assert property (@(posedge core_clk) disable iff (!nrst)
        take && !bad |=> !cmd_ready && !cmd_err) else $error("command not taken");
    AST_HIB_PIN: assert property (@(posedge core_clk) disable iff (!nrst)
        wake_valid && hib_r |-> wake_code == WAKE_PIN) else $error("hibernate left without pin");
    AST_PIN: assert property (@(posedge core_clk) disable iff (!nrst)
        wait_r && !wake_valid && $fell(wake_n) && (hib_r || src_r[SRC_PIN])
        |-> ##[1:3] (wake_valid && wake_code == WAKE_PIN)) else $error("pin wake missing");
    AST_SS: assert property (@(posedge core_clk) disable iff (!nrst)
        wait_r && !wake_valid && !hib_r && src_r[SRC_SS] && wake_n && $fell(ss_n)
        |-> ##[1:3] (wake_valid && wake_code == WAKE_SS)) else $error("select wake missing");
    AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (!nrst)
        wake_valid && wake_code == WAKE_TIMEOUT && !src_r[SRC_TAG]
        |-> cnt_r >= lim_r && cnt_r <= lim_r + 4) else $error("timeout length wrong");
    AST_TAG_HIT: assert property (@(posedge core_clk) disable iff (!nrst)
        wake_valid && wake_code == WAKE_TAG |-> src_r[SRC_TAG] && (dac8 > hi_r || dac8 < lo_r))
        else $error("tag wake inside thresholds");
    AST_TAG_MISS: assert property (@(posedge core_clk) disable iff (!nrst)
        wake_valid && wake_code == WAKE_TIMEOUT && src_r[SRC_TAG] |-> dac8 <= hi_r && dac8 >= lo_r)
        else $error("tag missed outside thresholds");
    AST_POWERUP: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(cmd_ready) && first_r |-> pu_r >= READY_DLY - 1 && pu_r <= READY_DLY + 4)
        else $error("power-up delay wrong");
endmodule : wetdc_assertions
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module testbench
    import wetdc_pkg::*;
;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr;
    logic [5:0] drive_current = 6'h00;
    int errors = 0;
    int tests_run = 0;
    int dac_m = 0;
    logic fast_osc_en, rf_on, wait_active;
    wetdc_if link ();
    wetdc_host wetdc_host_inst (.core_clk(core_clk), .nrst(nrst), .link(link.hst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    wetdc_dev #(.READY_DLY(20), .SLOW_DIV(4)) wetdc_dev_inst (.core_clk(core_clk), .nrst(nrst),
        .link(link.dev), .drive_current(drive_current), .fast_osc_en(fast_osc_en), .rf_on(rf_on),
        .wait_active(wait_active));
    wetdc_assertions #(.READY_DLY(20), .SLOW_DIV(4)) wetdc_assertions_inst (.core_clk(core_clk),
        .nrst(nrst), .wake_n(link.wake_n), .ss_n(link.ss_n), .cmd_valid(link.cmd_valid),
        .cmd_ready(link.cmd_ready), .cmd_err(link.cmd_err), .wake_valid(link.wake_valid),
        .cmd_src(link.cmd_src), .cmd_period(link.cmd_period), .cmd_lo(link.cmd_lo), .cmd_hi(link.cmd_hi),
        .cmd_max(link.cmd_max), .wake_code(link.wake_code), .dac_data(link.dac_data), .cmd_mode(link.cmd_mode));
    // Clock
    always #12.5 core_clk = ~core_clk;
    // One APB transfer, read data kept in rd
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Poll status until the device is back in ready state
    task automatic wait_done();
        repeat (4) @(posedge core_clk);
        do apb(1'b0, REG_STATUS, 32'h0); while (rd[STAT_BUSY] !== 1'b0 || rd[STAT_READY] !== 1'b1);
    endtask : wait_done
    // Reference model of the wake event
    function automatic int model(input int src, act, cur);
        if (act == 2) return 8'h08;
        if (act == 4) return 8'h10;
        if (src[1] && (cur * 4 > 8'h74 || cur * 4 < 8'h64)) return 8'h02;
        return 8'h01;
    endfunction : model
    // One idle command, optional pin or select pulse, then result check
    task automatic run(input wetdc_mode_e m, input int src, mx, act, cur);
        int e;
        e = model(src, act, cur);
        drive_current <= cur[5:0];
        apb(1'b1, REG_SRC, src);
        apb(1'b1, REG_THRESH, {8'h00, mx[7:0], 16'h7464});
        apb(1'b1, REG_CTRL, {26'h0, m, 4'h1});
        if (act != 0) begin
            repeat (40) @(posedge core_clk);
            `CHK({fast_osc_en, rf_on, wait_active}, 3'b001)
            apb(1'b1, REG_CTRL, {26'h0, m, act[3:0]});
        end
        wait_done();
        if (mx == 0 || mx == 31) begin
            `CHK(rd[STAT_ERR], 1'b1)
        end else begin
            `CHK(rd[STAT_VALID], m != MODE_HIBERNATE)
            if (m != MODE_HIBERNATE) `CHK(rd[15:8], e[7:0])
            if (src[1] && act == 0) dac_m = cur;
            if (src[1]) `CHK(rd[21:16], dac_m[5:0])
        end
        $display("test mode %0d src %h done", m, src);
    endtask : run
    // Counts and verdict
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // Watchdog
    initial begin
        #(100000 * 25);
        errors++;
        complete_run();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h6e281082));
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        apb(1'b0, REG_SRC, 32'h0);
        `CHK(rd[7:0], SRC_RESET)
        apb(1'b0, REG_TIMING, 32'h0);
        `CHK(rd, TIMING_RESET)
        apb(1'b0, REG_THRESH, 32'h0);
        `CHK(rd[23:0], THRESH_RESET)
        apb(1'b0, 12'h014, 32'h0);
        `CHK({pslverr, rd}, 33'h100000000)
        apb(1'b1, REG_TIMING, 32'h3f010100);
        apb(1'b1, REG_CTRL, {26'h0, MODE_SLEEP, 4'h2});
        wait_done();
        $display("test power-up done");
        run(MODE_SLEEP, 8'h08, 1, 2, 0);
        run(MODE_SLEEP, 8'h10, 1, 4, 0);
        run(MODE_HIBERNATE, 8'h08, 1, 2, 0);
        run(MODE_SLEEP, 8'h01, 1, 0, 0);
        run(MODE_SLEEP, 8'hc9, 1, 0, 0);
        run(MODE_SLEEP, 8'h08, 0, 0, 0);
        run(MODE_SLEEP, 8'h08, 31, 0, 0);
        run(MODE_TAG, 8'h0a, 1, 2, 27);
        for (int i = 0; i < 5; i++) begin
            run(MODE_TAG, 8'h0b, 1, 0, (i == 0) ? 27 : $urandom_range(63));
        end
        // Calibration sweep with a strong drive current: detection starts just below it
        drive_current <= 6'h3f;
        apb(1'b1, REG_CTRL, 32'h8);
        wait_done();
        `CHK(rd[STAT_CAL_DONE], 1'b1)
        `CHK(rd[STAT_REF_LSB +: 8], 8'hfb)
        apb(1'b0, REG_THRESH, 32'h0);
        `CHK(rd[15:0], 16'hfff3)
        $display("test calibration done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
